// >>> include/fdp_pkg.sv
// Package: constants, types and register map of the fan protection sequencer
package fdp_pkg;

    // ------------------------------------------------------------
    // Clock and protection times
    // ------------------------------------------------------------
    localparam int CLK_FREQ_MHZ = 10;          // Core clock rate
    localparam int OC_ALL_OFF_US = 1000;       // Offender off to all off
    localparam int OC_OFF_TIME_US = 100000;    // Overcurrent off time
    localparam int OC_MASK_NS = 2000;          // Overcurrent pulse mask
    localparam int TSD_PWM_OFF_US = 1000;      // Upper off before all off
    localparam int LOCK_OFF_US = 500000;       // Lock off period
    localparam int CL_MASK_NS = 1000;          // Current limit blanking
    // Cycle counts: least times round up, none below one cycle
    localparam int OC_ALL_OFF_CYC = OC_ALL_OFF_US * CLK_FREQ_MHZ;
    localparam int OC_OFF_TIME_CYC = OC_OFF_TIME_US * CLK_FREQ_MHZ;
    localparam int OC_MASK_CYC = (OC_MASK_NS * CLK_FREQ_MHZ + 999) / 1000;
    localparam int TSD_PWM_OFF_CYC = TSD_PWM_OFF_US * CLK_FREQ_MHZ;
    localparam int LOCK_OFF_CYC = LOCK_OFF_US * CLK_FREQ_MHZ;
    localparam int CL_MASK_CYC = (CL_MASK_NS * CLK_FREQ_MHZ + 999) / 1000;
    localparam int TMR_W = 24;                 // Width of the shared timer
    localparam logic [3:0] OC_LATCH_COUNT = 4'h8; // Shutdown count that latches
    localparam int N_SW = 4;                   // Output transistors

    // ------------------------------------------------------------
    // Register map (byte addresses, word aligned)
    // ------------------------------------------------------------
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_STATUS = 4'h4;
    localparam logic [3:0] REG_IRQ_STAT = 4'h8;
    localparam logic [3:0] REG_IRQ_MASK = 4'hc;
    localparam int CTRL_DRV_EN_BIT = 0;        // Drive enable
    localparam int CTRL_QS_EN_BIT = 1;         // Quick start permitted
    localparam logic [1:0] CTRL_RESET = 2'h3;
    localparam logic [5:0] IRQ_MASK_RESET = 6'h00;
    // Event bit positions, shared by status and mask
    localparam int EV_LOCK = 0;
    localparam int EV_CLIM = 1;
    localparam int EV_OC = 2;
    localparam int EV_OC_LATCH = 3;
    localparam int EV_TSD = 4;
    localparam int EV_UVLO = 5;
    localparam int N_EV = 6;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    // Analogue comparator and converter flags, all high-true
    typedef struct packed {
        logic [3:0] oc;          // Per-transistor overcurrent
        logic cur_lim;           // Sense node at current limit threshold
        logic over_temp;         // Junction at thermal shutdown level
        logic temp_ok;           // Junction cooled to recovery level
        logic motor_low;         // Motor supply at/below lower threshold
        logic ref_low;           // Regulated reference at/below lower
        logic motor_ok;          // Motor supply at/above upper threshold
        logic ref_ok;            // Regulated reference at/above upper
    } fdp_flags_type;

    // Commutation side: requested gates and PWM timing
    typedef struct packed {
        logic [3:0] gate_req;    // [1:0] upper, [3:2] lower transistors
        logic pwm_on;            // Pulse at each PWM on instant
        logic sw_edge;           // Pulse at each switching instant
        logic lock_trip;         // Pulse: lock detection fired
    } fdp_drive_type;

    typedef enum logic [3:0] {
        ST_RUN,
        ST_LOCK_OFF,
        ST_QS_CLEARED,
        ST_OC_ISOLATE,
        ST_OC_OFF,
        ST_OC_LATCHED,
        ST_TSD_PWM,
        ST_TSD_OFF,
        ST_UVLO
    } fdp_state_type;

endpackage : fdp_pkg

// >>> rtl/fdp_pulse_filter.sv
// Module: rejects flag pulses shorter than a set number of cycles
`timescale 1ns/1ps
`default_nettype none
module fdp_pulse_filter #(
    parameter int MASK_CYC = 20
) (
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic flag_i,
    output logic qual_o
);
    // ------------------------------------------------------------
    // Run length counter
    // ------------------------------------------------------------
    localparam int CW = $clog2(MASK_CYC + 1);
    localparam logic [CW-1:0] LAST = CW'(MASK_CYC - 1);
    logic [CW-1:0] run_q; // Cycles the flag has stood high

    // Counts while high, restarts on any low cycle
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            run_q <= '0;
            qual_o <= 1'b0;
        end else if (!flag_i) begin
            run_q <= '0;
            qual_o <= 1'b0;
        end else begin
            // Qualified once the pulse outlives the mask
            if (run_q != LAST) begin
                run_q <= run_q + 1'b1;
            end
            qual_o <= (run_q == LAST);
        end
    end
endmodule : fdp_pulse_filter
`default_nettype wire

// >>> rtl/fdp_sequencer.sv
// Module: fan driver protection and restart sequencer with Avalon slave
//
// Implementation choices: the address map and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module fdp_sequencer #(
    parameter int OC_ALL_OFF_CYC = fdp_pkg::OC_ALL_OFF_CYC,
    parameter int OC_OFF_TIME_CYC = fdp_pkg::OC_OFF_TIME_CYC,
    parameter int TSD_PWM_OFF_CYC = fdp_pkg::TSD_PWM_OFF_CYC,
    parameter int LOCK_OFF_CYC = fdp_pkg::LOCK_OFF_CYC
) (
    input wire logic mclk_i,
    input wire logic rst_n_i,
    // Avalon-MM slave
    input wire logic [3:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    // Converter outputs for the two analogue settings
    input wire logic speed_command_input_low_i, // At/below low threshold
    input wire logic min_duty_setting_high_i,   // At/above low threshold
    // Analogue flags and commutation timing
    input wire fdp_pkg::fdp_flags_type flags_i,
    input wire fdp_pkg::fdp_drive_type drive_i,
    // Power stage and status
    output logic [3:0] gate_o,
    output logic lock_detect_output_o,
    output logic irq_o
);
    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    localparam int TW = fdp_pkg::TMR_W;
    localparam logic [TW-1:0] OC_ISO_LAST = TW'(OC_ALL_OFF_CYC - 1);
    localparam logic [TW-1:0] OC_OFF_LAST = TW'(OC_OFF_TIME_CYC - 1);
    localparam logic [TW-1:0] TSD_LAST = TW'(TSD_PWM_OFF_CYC - 1);
    localparam logic [TW-1:0] LOCK_LAST = TW'(LOCK_OFF_CYC - 1);
    localparam logic [7:0] CLM_LAST = 8'(fdp_pkg::CL_MASK_CYC - 1);

    fdp_pkg::fdp_state_type state_q; // Sequencer state
    fdp_pkg::fdp_state_type state_d;
    logic [TW-1:0] tmr_q;            // Shared state timer
    logic [TW-1:0] clean_q;          // Clean run time since last retry
    logic [3:0] oc_cnt_q;            // Consecutive overcurrent shutdowns
    logic [3:0] oc_off_q;            // Transistors switched off singly
    logic [3:0] oc_qual;             // Filtered overcurrent flags
    logic oc_any;
    logic cl_off_q;                  // Upper held off until PWM on
    logic [7:0] clm_q;               // Current limit blanking counter
    logic cmd_low_q;                 // Previous speed command level
    logic cmd_reapplied;             // Command rose above threshold
    logic uv_low;
    logic uv_ok;
    logic qs_allowed;
    logic tmr_clr;
    logic [1:0] ctrl_q;              // Control register
    logic [5:0] irq_stat_q;          // Sticky event bits
    logic [5:0] irq_mask_q;          // Interrupt enables
    logic [5:0] ev;                  // Event pulses this cycle
    logic bus_go;                    // Access accepted this edge
    logic [31:0] rd_mux;

    // ------------------------------------------------------------
    // Flag qualification
    // ------------------------------------------------------------
    // One filter per transistor keeps pulse currents from tripping
    genvar g;
    generate
        for (g = 0; g < fdp_pkg::N_SW; g++) begin : g_oc
            fdp_pulse_filter #(
                .MASK_CYC(fdp_pkg::OC_MASK_CYC)
            ) u_oc_filt (
                .mclk_i(mclk_i),
                .rst_n_i(rst_n_i),
                .flag_i(flags_i.oc[g]),
                .qual_o(oc_qual[g])
            );
        end
    endgenerate

    assign oc_any = |oc_qual;
    // Either supply low trips; both must recover to leave
    assign uv_low = flags_i.motor_low | flags_i.ref_low;
    assign uv_ok = flags_i.motor_ok & flags_i.ref_ok;
    // Quick start off when minimum duty is set or software forbids it
    assign qs_allowed = !min_duty_setting_high_i
        && ctrl_q[fdp_pkg::CTRL_QS_EN_BIT];
    // Speed command leaving the low band counts as reapplied
    assign cmd_reapplied = cmd_low_q && !speed_command_input_low_i;

    // Remembers the command level for edge detection
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cmd_low_q <= 1'b1;
        end else begin
            cmd_low_q <= speed_command_input_low_i;
        end
    end

    // ------------------------------------------------------------
    // Sequencer next state
    // ------------------------------------------------------------
    // Priority: undervoltage, thermal, overcurrent, lock
    always_comb begin
        state_d = state_q;
        tmr_clr = 1'b0;
        if (uv_low && state_q != fdp_pkg::ST_UVLO) begin
            state_d = fdp_pkg::ST_UVLO;
            tmr_clr = 1'b1;
        end else if (flags_i.over_temp && state_q != fdp_pkg::ST_UVLO
                && state_q != fdp_pkg::ST_TSD_PWM
                && state_q != fdp_pkg::ST_TSD_OFF) begin
            state_d = fdp_pkg::ST_TSD_PWM;
            tmr_clr = 1'b1;
        end else begin
            case (state_q)
                fdp_pkg::ST_RUN: begin
                    // Offending transistor goes off at once
                    if (oc_any) begin
                        state_d = fdp_pkg::ST_OC_ISOLATE;
                        tmr_clr = 1'b1;
                    end else if (drive_i.lock_trip) begin
                        state_d = fdp_pkg::ST_LOCK_OFF;
                        tmr_clr = 1'b1;
                    end
                end
                fdp_pkg::ST_LOCK_OFF: begin
                    if (qs_allowed && speed_command_input_low_i) begin
                        state_d = fdp_pkg::ST_QS_CLEARED;
                    end else if (tmr_q == LOCK_LAST) begin
                        state_d = fdp_pkg::ST_RUN;
                    end
                end
                fdp_pkg::ST_QS_CLEARED: begin
                    // No wait for the rest of the off period
                    if (!speed_command_input_low_i) begin
                        state_d = fdp_pkg::ST_RUN;
                    end
                end
                fdp_pkg::ST_OC_ISOLATE: begin
                    if (tmr_q == OC_ISO_LAST) begin
                        state_d = fdp_pkg::ST_OC_OFF;
                    end
                end
                fdp_pkg::ST_OC_OFF: begin
                    // Timer runs on from detection, not from all off
                    if (oc_cnt_q == fdp_pkg::OC_LATCH_COUNT) begin
                        state_d = fdp_pkg::ST_OC_LATCHED;
                    end else if (tmr_q == OC_OFF_LAST) begin
                        state_d = fdp_pkg::ST_RUN;
                    end
                end
                fdp_pkg::ST_OC_LATCHED: begin
                    if (cmd_reapplied) begin
                        state_d = fdp_pkg::ST_RUN;
                    end
                end
                fdp_pkg::ST_TSD_PWM: begin
                    if (tmr_q == TSD_LAST) begin
                        state_d = fdp_pkg::ST_TSD_OFF;
                    end
                end
                fdp_pkg::ST_TSD_OFF: begin
                    if (flags_i.temp_ok && !flags_i.over_temp) begin
                        state_d = fdp_pkg::ST_RUN;
                    end
                end
                fdp_pkg::ST_UVLO: begin
                    if (uv_ok && !uv_low) begin
                        state_d = fdp_pkg::ST_RUN;
                    end
                end
                default: begin
                    state_d = fdp_pkg::ST_UVLO;
                end
            endcase
        end
    end

    // State register; power-up starts in lockout until supplies settle
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_q <= fdp_pkg::ST_UVLO;
        end else begin
            state_q <= state_d;
        end
    end

    // Shared timer, restarted on every timed entry except overcurrent off
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tmr_q <= '0;
        end else if (tmr_clr) begin
            tmr_q <= '0;
        end else if (tmr_q != {TW{1'b1}}) begin
            tmr_q <= tmr_q + 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Overcurrent retry counting
    // ------------------------------------------------------------
    // A full off time of clean running ends the streak; supply or
    // command reapplied also clears the count.
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            oc_cnt_q <= '0;
            clean_q <= '0;
        end else if (state_q == fdp_pkg::ST_UVLO
                || (state_q == fdp_pkg::ST_OC_LATCHED && cmd_reapplied)) begin
            oc_cnt_q <= '0;
            clean_q <= '0;
        end else if (state_q == fdp_pkg::ST_RUN
                && state_d == fdp_pkg::ST_OC_ISOLATE) begin
            oc_cnt_q <= oc_cnt_q + 1'b1;
            clean_q <= '0;
        end else if (state_q == fdp_pkg::ST_RUN) begin
            if (clean_q == OC_OFF_LAST) begin
                oc_cnt_q <= '0;
            end else begin
                clean_q <= clean_q + 1'b1;
            end
        end else begin
            clean_q <= '0;
        end
    end

    // Remembers which transistors tripped during isolation
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            oc_off_q <= '0;
        end else if (state_q == fdp_pkg::ST_RUN
                || state_q == fdp_pkg::ST_OC_ISOLATE) begin
            oc_off_q <= oc_off_q | oc_qual;
        end else begin
            oc_off_q <= '0;
        end
    end

    // ------------------------------------------------------------
    // Current limit
    // ------------------------------------------------------------
    // Blanking after each switch hides the recovery spike
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            clm_q <= '0;
        end else if (drive_i.sw_edge || drive_i.pwm_on) begin
            clm_q <= CLM_LAST;
        end else if (clm_q != 8'h00) begin
            clm_q <= clm_q - 1'b1;
        end
    end

    // Upper off from a limit event until the next PWM on instant
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cl_off_q <= 1'b0;
        end else if (drive_i.pwm_on) begin
            cl_off_q <= 1'b0;
        end else if (flags_i.cur_lim && clm_q == 8'h00) begin
            cl_off_q <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Gate outputs
    // ------------------------------------------------------------
    // Registered so a comparator glitch never reaches a gate directly;
    // costs one cycle of reaction time.
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            gate_o <= '0;
        end else if (!ctrl_q[fdp_pkg::CTRL_DRV_EN_BIT]) begin
            gate_o <= '0;
        end else begin
            case (state_d)
                fdp_pkg::ST_RUN: begin
                    // Limit event drops upper pair, lower keeps going
                    gate_o <= drive_i.gate_req & ~oc_qual
                        & {2'b11, {2{!cl_off_q}}};
                end
                fdp_pkg::ST_OC_ISOLATE: begin
                    gate_o <= drive_i.gate_req & ~(oc_off_q | oc_qual)
                        & {2'b11, {2{!cl_off_q}}};
                end
                fdp_pkg::ST_TSD_PWM: begin
                    gate_o <= drive_i.gate_req & 4'hc;
                end
                default: begin
                    gate_o <= '0;
                end
            endcase
        end
    end

    // Lock indication stands through the lock off period
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            lock_detect_output_o <= 1'b0;
        end else begin
            lock_detect_output_o <= (state_d == fdp_pkg::ST_LOCK_OFF);
        end
    end

    // ------------------------------------------------------------
    // Events and interrupt
    // ------------------------------------------------------------
    always_comb begin
        ev = '0;
        ev[fdp_pkg::EV_LOCK] = state_q == fdp_pkg::ST_RUN
            && state_d == fdp_pkg::ST_LOCK_OFF;
        ev[fdp_pkg::EV_CLIM] = !cl_off_q && flags_i.cur_lim
            && clm_q == 8'h00 && !drive_i.pwm_on;
        ev[fdp_pkg::EV_OC] = state_q == fdp_pkg::ST_RUN
            && state_d == fdp_pkg::ST_OC_ISOLATE;
        ev[fdp_pkg::EV_OC_LATCH] = state_q != fdp_pkg::ST_OC_LATCHED
            && state_d == fdp_pkg::ST_OC_LATCHED;
        ev[fdp_pkg::EV_TSD] = state_q != fdp_pkg::ST_TSD_PWM
            && state_d == fdp_pkg::ST_TSD_PWM;
        ev[fdp_pkg::EV_UVLO] = state_q != fdp_pkg::ST_UVLO
            && state_d == fdp_pkg::ST_UVLO;
    end

    // Write one to clear; a new event in the same cycle wins
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            irq_stat_q <= '0;
        end else if (bus_go && avs_write_i
                && avs_address_i == fdp_pkg::REG_IRQ_STAT) begin
            irq_stat_q <= (irq_stat_q & ~avs_writedata_i[5:0]) | ev;
        end else begin
            irq_stat_q <= irq_stat_q | ev;
        end
    end

    // Level interrupt, one cycle behind the status bits
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |(irq_stat_q & irq_mask_q);
        end
    end

    // ------------------------------------------------------------
    // Avalon-MM slave
    // ------------------------------------------------------------
    // One wait cycle per access: waitrequest drops for one cycle
    assign bus_go = (avs_read_i || avs_write_i) && !avs_waitrequest_o;

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            avs_waitrequest_o <= 1'b1;
        end else if ((avs_read_i || avs_write_i) && avs_waitrequest_o) begin
            avs_waitrequest_o <= 1'b0;
        end else begin
            avs_waitrequest_o <= 1'b1;
        end
    end

    // Read mux; unmapped words read zero
    always_comb begin
        rd_mux = '0;
        case (avs_address_i)
            fdp_pkg::REG_CTRL: rd_mux[1:0] = ctrl_q;
            fdp_pkg::REG_STATUS: begin
                rd_mux[3:0] = state_q;
                rd_mux[7:4] = oc_cnt_q;
                rd_mux[11:8] = gate_o;
                rd_mux[12] = cl_off_q;
            end
            fdp_pkg::REG_IRQ_STAT: rd_mux[5:0] = irq_stat_q;
            fdp_pkg::REG_IRQ_MASK: rd_mux[5:0] = irq_mask_q;
            default: rd_mux = '0;
        endcase
    end

    // Read data is loaded as waitrequest falls and then holds
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            avs_readdata_o <= '0;
        end else if (avs_read_i && avs_waitrequest_o) begin
            avs_readdata_o <= rd_mux;
        end
    end

    // Control and mask registers; writes to the status word and unmapped words are ignored
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ctrl_q <= fdp_pkg::CTRL_RESET;
            irq_mask_q <= fdp_pkg::IRQ_MASK_RESET;
        end else if (bus_go && avs_write_i) begin
            if (avs_address_i == fdp_pkg::REG_CTRL) begin
                ctrl_q <= avs_writedata_i[1:0];
            end
            if (avs_address_i == fdp_pkg::REG_IRQ_MASK) begin
                irq_mask_q <= avs_writedata_i[5:0];
            end
        end
    end

endmodule : fdp_sequencer
`default_nettype wire

// >>> verification/fdp_assertions.sv
// Checker: protection timing at the sequencer ports
`timescale 1ns/1ps
`default_nettype none
module fdp_assertions #(parameter int OC_ALL_OFF_CYC = 10000) (
    input wire logic mclk_i, rst_n_i, speed_command_input_low_i,
    input wire logic min_duty_setting_high_i, lock_detect_output_o,
    input wire fdp_pkg::fdp_flags_type flags_i,
    input wire logic [3:0] gate_o
);
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);
    logic [4:0] run_q; // Overcurrent run length, saturating
    logic [15:0] t_q; // Cycles since qualification, parked at top
    always_ff @(posedge mclk_i or negedge rst_n_i)
        if (!rst_n_i) run_q <= 5'h00;
        else run_q <= flags_i.oc[0] ? run_q + 5'(run_q != 5'h1f) : 5'h00;
    always_ff @(posedge mclk_i or negedge rst_n_i)
        if (!rst_n_i) t_q <= 16'hffff;
        else t_q <= run_q == 5'h14 ? 16'h0001 : t_q + 16'(t_q != 16'hffff);
    sequence hot_s; flags_i.over_temp ##1 !flags_i.temp_ok [*3]; endsequence
    uvlo_low_a: assert property (flags_i.motor_low || flags_i.ref_low
        |-> ##[1:2] gate_o == 4'h0) else $error("gates on at low supply");
    uvlo_hold_a: assert property (!(flags_i.motor_ok && flags_i.ref_ok)
        |-> ##[1:2] gate_o == 4'h0) else $error("left lockout early");
    oc_cut_a: assert property (run_q == 5'h14
        |-> ##[1:2] !gate_o[0]) else $error("offender still on");
    oc_all_a: assert property (t_q == OC_ALL_OFF_CYC + 3
        |-> gate_o == 4'h0) else $error("gates on after overcurrent");
    tsd_upper_a: assert property (flags_i.over_temp
        |-> ##[1:2] gate_o[1:0] == 2'h0) else $error("upper on when hot");
    tsd_cool_a: assert property (hot_s |-> gate_o[1:0] == 2'h0)
        else $error("resumed before cooling");
    lock_off_a: assert property (lock_detect_output_o
        && $past(lock_detect_output_o) |-> gate_o == 4'h0) else $error("lock");
    qs_clear_a: assert property (lock_detect_output_o
        && speed_command_input_low_i && !min_duty_setting_high_i
        |-> ##[1:2] !lock_detect_output_o) else $error("lock not cleared");
    qs_block_a: assert property (lock_detect_output_o
        && speed_command_input_low_i && min_duty_setting_high_i
        |=> lock_detect_output_o) else $error("quick start not blocked");
endmodule : fdp_assertions
`default_nettype wire

// >>> verification/fdp_motor_model.sv
// Partner: motor and power stage flags seen by the sequencer
`timescale 1ns/1ps
`default_nettype none
module fdp_motor_model (
    input wire logic [3:0] gate_i,
    input wire logic fault_i, lim_i, // Commanded short, heavy load
    input wire logic [1:0] sup_i, // {motor, reference} healthy
    input wire logic [1:0] temp_i, // 2 hot, 1 between levels, 0 cool
    output var fdp_pkg::fdp_flags_type flags_o
);
    // Output shorted to ground: only a conducting upper switch sees it
    assign flags_o = '{{2'h0, gate_i[1:0] & {2{fault_i}}}, lim_i,
        temp_i == 2'h2,
        temp_i == 2'h0, !sup_i[1], !sup_i[0], sup_i[1], sup_i[0]};
endmodule : fdp_motor_model
`default_nettype wire

// >>> verification/testbench.sv
// Testbench: protection scenarios for the fan sequencer
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic mclk_i = 1'b0, rst_n_i = 1'b0, rd = 1'b0, wr = 1'b0, wreq, lock, irq;
    logic spd = 1'b0, mind = 1'b0, flt = 1'b0, lim = 1'b0;
    logic [3:0] ad = 4'h0, gate;
    logic [31:0] wd = 32'h0, rdat, q;
    logic [1:0] sup = 2'h0, tmp = 2'h0;
    fdp_pkg::fdp_drive_type drv = '{4'h5, 1'b0, 1'b0, 1'b0};
    fdp_pkg::fdp_flags_type fl;
    int failures = 0, num_checks = 0, cyc = 0;
    fdp_sequencer #(.OC_ALL_OFF_CYC(50), .OC_OFF_TIME_CYC(300),
        .TSD_PWM_OFF_CYC(50), .LOCK_OFF_CYC(400)) uut (.mclk_i, .rst_n_i,
        .avs_address_i(ad), .avs_read_i(rd), .avs_write_i(wr),
        .avs_writedata_i(wd), .avs_readdata_o(rdat), .avs_waitrequest_o(wreq),
        .speed_command_input_low_i(spd), .min_duty_setting_high_i(mind),
        .flags_i(fl), .drive_i(drv), .gate_o(gate),
        .lock_detect_output_o(lock), .irq_o(irq));
    fdp_motor_model mdl (.gate_i(gate), .fault_i(flt), .lim_i(lim),
        .sup_i(sup), .temp_i(tmp), .flags_o(fl));
    initial forever #50 mclk_i = ~mclk_i;
    always @(posedge mclk_i) if (++cyc == 20000) begin
        failures++;
        close_out();
    end
    task automatic chk(input string n, input logic [31:0] s, e);
        num_checks++;
        if (s !== e) begin
            failures++;
            $display("CHECK FAILED %s exp %h seen %h", n, e, s);
        end
    endtask : chk
    task automatic tk(input int n); repeat (n) @(posedge mclk_i); endtask : tk
    // Holds the request until waitrequest is seen low at an edge
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge mclk_i);
        {rd, wr, ad, wd} <= {!w, w, a, d};
        do @(posedge mclk_i); while (wreq !== 1'b0);
        q = rdat;
        {rd, wr} <= 2'h0;
    endtask : bus
    task automatic t_oc;
        bus(1'h1, 4'hc, 32'h4);
        flt <= 1'b1; tk(10); flt <= 1'b0; tk(5);
        chk("short pulse", gate, 4'h5);
        flt <= 1'b1; tk(24); chk("offender", gate, 4'h4);
        flt <= 1'b0; tk(60); chk("all off", gate, 4'h0);
        bus(1'h0, 4'h4, 32'h0); chk("count", q[7:4], 4'h1);
        chk("irq", irq, 1'b1);
        bus(1'h1, 4'h8, 32'h4); tk(3); chk("irq clr", irq, 1'b0);
        bus(1'h0, 4'h2, 32'h0); chk("unmapped", q, 32'h0);
        tk(260); chk("resume", gate, 4'h5);
    endtask : t_oc
    task automatic t_misc;
        bus(1'h1, 4'h0, 32'h2); bus(1'h0, 4'h0, 32'h0);
        chk("ctrl", q, 32'h2);
        chk("drive off", gate, 4'h0);
        bus(1'h1, 4'h0, 32'h3);
        lim <= 1'b1; tk(4); chk("limit", gate, 4'h4);
        lim <= 1'b0; drv.pwm_on <= 1'b1; tk(1); drv.pwm_on <= 1'b0; tk(3);
        chk("pwm on", gate, 4'h5);
        {lim, drv.sw_edge} <= 2'h3; tk(1); drv.sw_edge <= 1'b0; tk(4);
        lim <= 1'b0; chk("blanked", gate, 4'h5);
        tmp <= 2'h2; tk(4); chk("tsd upper", gate, 4'h4);
        tk(60); chk("tsd all", gate, 4'h0);
        chk("masked", irq, 1'b0);
        tmp <= 2'h1; tk(10); chk("warm", gate, 4'h0);
        tmp <= 2'h0; tk(4); chk("cool", gate, 4'h5);
        drv.lock_trip <= 1'b1; tk(1); drv.lock_trip <= 1'b0; tk(4);
        chk("lock off", {lock, gate}, 5'h10);
        {mind, spd} <= 2'h3; tk(10); chk("qs off", lock, 1'b1);
        mind <= 1'b0; tk(10); chk("lock clr", lock, 1'b0);
        spd <= 1'b0; tk(3); chk("restart", gate, 4'h5);
        drv.lock_trip <= 1'b1; tk(1); drv.lock_trip <= 1'b0; tk(402);
        chk("lock end", {lock, gate}, 5'h05);
        flt <= 1'b1; tk(3000); bus(1'h0, 4'h4, 32'h0);
        chk("latched", q[3:0], 4'h5);
        {flt, spd} <= 2'h1; tk(10); spd <= 1'b0; tk(5);
        chk("unlatch", gate, 4'h5);
        sup <= 2'h1; tk(3); chk("uvlo", gate, 4'h0);
    endtask : t_misc
    task automatic close_out;
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : close_out
    initial begin
        tk(5); rst_n_i <= 1'b1; sup <= 2'h2; tk(5);
        bus(1'h0, 4'h4, 32'h0); chk("one low", q[3:0], 4'h8);
        sup <= 2'h3; tk(5); chk("run", gate, 4'h5);
        t_oc(); t_misc(); close_out();
    end
endmodule : testbench
bind fdp_sequencer fdp_assertions #(.OC_ALL_OFF_CYC(OC_ALL_OFF_CYC)) u_chk (
    .mclk_i, .rst_n_i, .speed_command_input_low_i, .min_duty_setting_high_i,
    .lock_detect_output_o, .flags_i, .gate_o);
`default_nettype wire
